/* File: hw/dso_pkg.sv */
// constants, carrier types and states for the sync-out unit control block
package dso_pkg;
   localparam logic [11:0] OWN_ADDR = 12'h980;
   localparam logic [11:0] ACT_ADDR = 12'h981;
   localparam logic [11:0] PLEN_ADDR = 12'h982;
   localparam logic [11:0] PLENH_ADDR = 12'h983;
   localparam logic [11:0] ASTAT_ADDR = 12'h984;
   localparam logic [11:0] S0STAT_ADDR = 12'h98E;
   localparam logic [11:0] S1STAT_ADDR = 12'h98F;
   localparam logic [11:0] START_ADDR = 12'h990;
   localparam logic [11:0] NEXT1_ADDR = 12'h998;
   localparam logic [11:0] CYC0_ADDR = 12'h9A0;
   localparam logic [11:0] CYC1_ADDR = 12'h9A4;
   localparam logic [11:0] BLK8_MASK = 12'h007;
   localparam logic [11:0] BLK4_MASK = 12'h003;
   localparam int OWN_SYNC = 0;
   localparam int OWN_LATCH0 = 4;
   localparam int OWN_LATCH1 = 5;
   localparam logic [7:0] OWN_WMASK = 8'h31;
   localparam logic [7:0] OWN_RESET = 8'h00;
   localparam int ACT_UNIT = 0;
   localparam int ACT_GEN0 = 1;
   localparam int ACT_GEN1 = 2;
   localparam int ACT_AUTO = 3;
   localparam int ACT_EXT = 4;
   localparam int ACT_CHECK = 5;
   localparam int ACT_NEAR = 6;
   localparam int ACT_DEBUG = 7;
   localparam logic [7:0] ACT_RESET = 8'h00;
   localparam logic [15:0] PLEN_RESET = 16'h0000;
   localparam int NEAR_SHORT_BIT = 31;
   localparam int PULSE_UNIT_NS = 10;
   localparam int CLK_PERIOD_NS = 40;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [7:0] wdata;
   } dso_req_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_DONE = 2'b10
   } dso_state_type;
endpackage

/* File: hw/dso_sync_unit.sv */
// sync-out unit control, activation, pulse generation and event flags
//
// Contract
// - Ownership bit 0 picks sync-out owner; only network side writes it.
// - Bit 4 owns latch unit 0, forced host when system time host-controlled.
// - Bit 5 owns latch unit 1; its latch interrupt goes to that owner.
// - Activation bit 0 enables whole unit; resets to zero.
// - Activation bits 1 and 2 enable first and second sync outputs.
// - With bit 3 set, start time write sets the unit activation bit.
// - With bit 4 set, a 32-bit start time is extended to 64 bits.
// - Bit 5 on: start time outside near future fires at once.
// - Bit 6 picks near-future window: half width or 2^31 ns.
// - Writing bit 7 fires one debug pulse on enabled outputs; reads zero.
// - Pulse length in 10 ns units from config; zero means acknowledge mode.
// - Status bits 0 and 1 show first pulse of each output pending.
// - Status bit 2 holds plausibility result taken at activation.
// - Without write-ack, host read of first status clears event bit 2.
// - With write-ack, host write of first status clears event bit 2.
// - Second status access clears event bit 3, read or write by mode.
// - Start time write sets begin time; read gives next first pulse time.
// - Lower-only start time write in one frame gets upper half extended.
// - Read-only register gives next second-output pulse time.
// - First cycle time zero means single shot; else pulse interval.
// - Second cycle time is delay of second pulse after first.
`timescale 1ns/1ps
module dso_sync_unit import dso_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire dso_req_type netReq,
   input wire dso_req_type hostReq,
   input wire logic writeAckEn,
   input wire logic sysTimeHostCtrl,
   input wire logic frameEnd,
   input wire logic [63:0] sysTime,
   input wire logic cfgLoad,
   input wire logic [15:0] cfgPulseLen,
   input wire logic [1:0] latchIrq,
   output logic [1:0] latchIrqNet,
   output logic [1:0] latchIrqHost,
   output logic [1:0] syncOut,
   output logic [1:0] appEventReq,
   output logic [7:0] netRdata,
   output logic [7:0] hostRdata
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] own_ff;
   logic [7:0] act_ff;
   logic [15:0] pulseLen_ff;
   logic [63:0] next0_ff;
   logic [63:0] next1_ff;
   logic [31:0] cyc0_ff;
   logic [31:0] cyc1_ff;
   logic [1:0] pend_ff;
   logic outside_ff;
   logic armed1_ff;
   logic lowWr_ff;
   logic highWr_ff;
   dso_state_type state_ff;
   logic [7:0] netRdata_ff;
   logic [7:0] hostRdata_ff;
   logic syncOut_ff [2];
   logic appEvt_ff [2];
   logic [15:0] cnt_ff [2];
   logic [7:0] ownEff;
   dso_req_type wReq;
   logic startWr;
   logic commit;
   logic activate;
   logic [63:0] startDiff;
   logic [63:0] due0Diff;
   logic [63:0] due1Diff;
   logic outsideNow;
   logic fire0;
   logic fire1;
   logic debugPulse;
   logic [1:0] start;
   logic [1:0] statAcc;
   logic [1:0] ackClr;
   logic [15:0] plenCyc;

   function automatic logic inBlock(input logic [11:0] a, input logic [11:0] b,
                                    input logic [11:0] m);
      return (a & ~m) == b;
   endfunction

   function automatic logic [7:0] readByte(input logic [11:0] a);
      logic [7:0] r;
      r = 8'h00;
      if (a == OWN_ADDR) begin
         r = ownEff;
      end else if (a == ACT_ADDR) begin
         r = act_ff;
      end else if (a == PLEN_ADDR) begin
         r = pulseLen_ff[7:0];
      end else if (a == PLENH_ADDR) begin
         r = pulseLen_ff[15:8];
      end else if (a == ASTAT_ADDR) begin
         r = {5'h00, outside_ff, pend_ff};
      end else if (a == S0STAT_ADDR) begin
         r = {7'h00, pend_ff[0]};
      end else if (a == S1STAT_ADDR) begin
         r = {7'h00, pend_ff[1]};
      end else if (inBlock(a, START_ADDR, BLK8_MASK)) begin
         r = next0_ff[8 * a[2:0] +: 8];
      end else if (inBlock(a, NEXT1_ADDR, BLK8_MASK)) begin
         r = next1_ff[8 * a[2:0] +: 8];
      end else if (inBlock(a, CYC0_ADDR, BLK4_MASK)) begin
         r = cyc0_ff[8 * a[1:0] +: 8];
      end else if (inBlock(a, CYC1_ADDR, BLK4_MASK)) begin
         r = cyc1_ff[8 * a[1:0] +: 8];
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // ownership and latch interrupt routing
   assign ownEff = own_ff | {3'h0, sysTimeHostCtrl, 4'h0};
   assign latchIrqHost = latchIrq & {ownEff[OWN_LATCH1], ownEff[OWN_LATCH0]};
   assign latchIrqNet = latchIrq & ~{ownEff[OWN_LATCH1], ownEff[OWN_LATCH0]};

   always_ff @(posedge clk) begin
      if (reset) begin
         own_ff <= OWN_RESET;
      end else if (netReq.wr && netReq.addr == OWN_ADDR) begin
         own_ff <= netReq.wdata & OWN_WMASK;
      end
   end

   // only the owning side writes the activation, start time and cycle time registers; the other side's writes to them are ignored
   assign wReq = ownEff[OWN_SYNC] ? hostReq : netReq;

   ////////////////////////////////////////////////////////////////////////////
   // start time capture and activation
   assign startWr = wReq.wr && inBlock(wReq.addr, START_ADDR, BLK8_MASK) &&
                    !act_ff[ACT_UNIT];
   assign commit = frameEnd && !startWr && (lowWr_ff || highWr_ff);
   assign activate = (state_ff == ST_IDLE) && act_ff[ACT_UNIT];
   assign startDiff = next0_ff - sysTime;
   // a start time in the past wraps to a negative difference
   assign outsideNow = act_ff[ACT_NEAR] ? (|startDiff[63:NEAR_SHORT_BIT])
                                        : startDiff[63];
   assign debugPulse = wReq.wr && wReq.addr == ACT_ADDR && wReq.wdata[ACT_DEBUG];

   always_ff @(posedge clk) begin
      if (reset) begin
         lowWr_ff <= 1'b0;
         highWr_ff <= 1'b0;
      end else if (startWr) begin
         if (wReq.addr[2]) begin
            highWr_ff <= 1'b1;
         end else begin
            lowWr_ff <= 1'b1;
         end
      end else if (frameEnd) begin
         lowWr_ff <= 1'b0;
         highWr_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         act_ff <= ACT_RESET;
      end else begin
         if (wReq.wr && wReq.addr == ACT_ADDR) begin
            act_ff <= {1'b0, wReq.wdata[6:0]};
         end
         if (commit && act_ff[ACT_AUTO]) begin
            act_ff[ACT_UNIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         next0_ff <= 64'h0000000000000000;
      end else if (startWr) begin
         next0_ff[8 * wReq.addr[2:0] +: 8] <= wReq.wdata;
      end else if (commit && act_ff[ACT_EXT] && !highWr_ff) begin
         // pick the upper half that puts the start time at or after now
         next0_ff[63:32] <= sysTime[63:32] +
                            {31'h00000000, next0_ff[31:0] < sysTime[31:0]};
      end else if (activate && act_ff[ACT_CHECK] && outsideNow) begin
         next0_ff <= sysTime;
      end else if (fire0) begin
         next0_ff <= next0_ff + {32'h00000000, cyc0_ff};
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cyc0_ff <= 32'h00000000;
         cyc1_ff <= 32'h00000000;
      end else if (wReq.wr && inBlock(wReq.addr, CYC0_ADDR, BLK4_MASK)) begin
         cyc0_ff[8 * wReq.addr[1:0] +: 8] <= wReq.wdata;
      end else if (wReq.wr && inBlock(wReq.addr, CYC1_ADDR, BLK4_MASK)) begin
         cyc1_ff[8 * wReq.addr[1:0] +: 8] <= wReq.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pulseLen_ff <= PLEN_RESET;
      end else if (cfgLoad) begin
         pulseLen_ff <= cfgPulseLen;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // schedule
   assign due0Diff = sysTime - next0_ff;
   assign due1Diff = sysTime - next1_ff;
   assign fire0 = (state_ff == ST_RUN) && !due0Diff[63];
   assign fire1 = (state_ff != ST_IDLE) && act_ff[ACT_UNIT] && armed1_ff &&
                  !due1Diff[63];

   always_ff @(posedge clk) begin
      if (reset || !act_ff[ACT_UNIT]) begin
         state_ff <= ST_IDLE;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               state_ff <= ST_RUN;
            end
            ST_RUN: begin
               if (fire0 && cyc0_ff == 32'h00000000) begin
                  state_ff <= ST_DONE;
               end
            end
            default: begin
               state_ff <= state_ff;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         next1_ff <= 64'h0000000000000000;
         armed1_ff <= 1'b0;
      end else if (fire0) begin
         next1_ff <= next0_ff + {32'h00000000, cyc1_ff};
         armed1_ff <= 1'b1;
      end else if (fire1 || !act_ff[ACT_UNIT]) begin
         armed1_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !act_ff[ACT_UNIT]) begin
         pend_ff <= 2'h0;
      end else if (activate) begin
         pend_ff <= {act_ff[ACT_GEN1], act_ff[ACT_GEN0]};
      end else begin
         if (fire0) begin
            pend_ff[0] <= 1'b0;
         end
         if (fire1) begin
            pend_ff[1] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         outside_ff <= 1'b0;
      end else if (activate) begin
         outside_ff <= outsideNow;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs and event flags
   assign plenCyc = 16'((32'(pulseLen_ff) * PULSE_UNIT_NS + CLK_PERIOD_NS - 1) /
                        CLK_PERIOD_NS);
   // a debug write carries its own enables, so it obeys the bits written with it
   assign start[0] = (act_ff[ACT_GEN0] && fire0) ||
                     (debugPulse && wReq.wdata[ACT_GEN0]);
   assign start[1] = (act_ff[ACT_GEN1] && fire1) ||
                     (debugPulse && wReq.wdata[ACT_GEN1]);
   assign statAcc[0] = writeAckEn ? (hostReq.wr && hostReq.addr == S0STAT_ADDR)
                                  : (hostReq.rd && hostReq.addr == S0STAT_ADDR);
   assign statAcc[1] = writeAckEn ? (hostReq.wr && hostReq.addr == S1STAT_ADDR)
                                  : (hostReq.rd && hostReq.addr == S1STAT_ADDR);
   assign ackClr[0] = statAcc[0] || (netReq.rd && netReq.addr == S0STAT_ADDR);
   assign ackClr[1] = statAcc[1] || (netReq.rd && netReq.addr == S1STAT_ADDR);

   generate
      for (genvar i = 0; i < 2; i++) begin : g_out
         always_ff @(posedge clk) begin
            if (reset) begin
               syncOut_ff[i] <= 1'b0;
               cnt_ff[i] <= 16'h0000;
            end else if (start[i]) begin
               syncOut_ff[i] <= 1'b1;
               cnt_ff[i] <= plenCyc;
            end else if (pulseLen_ff == PLEN_RESET) begin
               if (ackClr[i]) begin
                  syncOut_ff[i] <= 1'b0;
               end
            end else if (cnt_ff[i] > 16'h0001) begin
               cnt_ff[i] <= cnt_ff[i] - 16'h0001;
            end else begin
               syncOut_ff[i] <= 1'b0;
               cnt_ff[i] <= 16'h0000;
            end
         end

         // a new pulse in the clearing cycle keeps its event
         always_ff @(posedge clk) begin
            if (reset) begin
               appEvt_ff[i] <= 1'b0;
            end else if (start[i]) begin
               appEvt_ff[i] <= 1'b1;
            end else if (statAcc[i]) begin
               appEvt_ff[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign syncOut = {syncOut_ff[1], syncOut_ff[0]};
   assign appEventReq = {appEvt_ff[1], appEvt_ff[0]};

   always_ff @(posedge clk) begin
      if (reset) begin
         netRdata_ff <= 8'h00;
         hostRdata_ff <= 8'h00;
      end else begin
         if (netReq.rd) begin
            netRdata_ff <= readByte(netReq.addr);
         end
         if (hostReq.rd) begin
            hostRdata_ff <= readByte(hostReq.addr);
         end
      end
   end

   assign netRdata = netRdata_ff;
   assign hostRdata = hostRdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence shortPulse0;
      syncOut[0] ##1 !syncOut[0];
   endsequence

   debug_self_clear_a: assert property (!act_ff[ACT_DEBUG])
      else $error("debug bit stored");
   gen0_gate_a: assert property ($rose(syncOut[0]) |->
                                 $past(act_ff[ACT_GEN0] || wReq.wdata[ACT_GEN0] && debugPulse))
      else $error("first output pulsed while disabled");
   gen1_gate_a: assert property ($rose(syncOut[1]) |->
                                 $past(act_ff[ACT_GEN1] || wReq.wdata[ACT_GEN1] && debugPulse))
      else $error("second output pulsed while disabled");
   own_force_a: assert property (sysTimeHostCtrl && latchIrq[0] |->
                                 latchIrqHost[0] && !latchIrqNet[0])
      else $error("latch 0 not routed to host");
   unit_start_a: assert property ($rose(act_ff[ACT_UNIT]) |-> ##1 state_ff == ST_RUN)
      else $error("unit did not start");
   single_shot_a: assert property (fire0 && cyc0_ff == 32'h00000000 |=>
                                   state_ff == ST_DONE ##1 !fire0)
      else $error("single shot repeated");
   plaus_jump_a: assert property (activate && act_ff[ACT_CHECK] && outsideNow |=>
                                  next0_ff == $past(sysTime) && outside_ff)
      else $error("out of window start not immediate");
   evt_clear_a: assert property (statAcc[0] && !start[0] |=> !appEventReq[0])
      else $error("event bit 2 not cleared");
   evt_set_wins_a: assert property (start[1] && statAcc[1] |=> appEventReq[1])
      else $error("event bit 3 lost on clear");
   ack_hold_a: assert property (pulseLen_ff == PLEN_RESET && syncOut[0] &&
                                !ackClr[0] && !start[0] |=> syncOut[0])
      else $error("ack mode output dropped");
   pulse_len_a: assert property (start[0] && pulseLen_ff == 16'h0004 &&
                                 !debugPulse |=> shortPulse0)
      else $error("40 ns pulse wrong length");
endmodule

/* File: test/dso_time_model.sv */
// system time keeper standing in front of the sync-out unit
`timescale 1ns/1ps
module dso_time_model #(
   parameter logic [63:0] INIT_TIME = 64'h0000000500001000
) (
   input wire logic clk,
   input wire logic reset,
   output logic [63:0] sysTime
);
   initial begin
      sysTime = INIT_TIME;
   end
   // advances on the falling edge so the unit never samples it mid-update
   always @(negedge clk) begin
      if (reset) begin
         sysTime <= INIT_TIME;
      end else begin
         sysTime <= sysTime + 64'h28;
      end
   end
endmodule

/* File: test/dso_sync_unit_tb.sv */
// self-checking bench for the sync-out unit control block
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin nErrors++; \
   $display("unexpected at %0t: got %0h want %0h", $time, (got), (exp)); end end
module dso_sync_unit_tb import dso_pkg::*;;
   logic clk = 1'b0;
   logic reset = 1'b1;
   dso_req_type netReq = '0;
   dso_req_type hostReq = '0;
   logic writeAckEn = 1'b0;
   logic sysTimeHostCtrl = 1'b0;
   logic frameEnd = 1'b0;
   logic cfgLoad = 1'b0;
   logic [15:0] cfgPulseLen = 16'h0000;
   logic [1:0] latchIrq = 2'b00;
   logic [63:0] sysTime;
   logic [1:0] latchIrqNet, latchIrqHost, syncOut, appEventReq;
   logic [7:0] netRdata, hostRdata;
   int nErrors = 0;
   int compares = 0;
   int cycles = 0;

   dso_time_model tm (.clk(clk), .reset(reset), .sysTime(sysTime));
   dso_sync_unit uut (.clk(clk), .reset(reset), .netReq(netReq), .hostReq(hostReq),
      .writeAckEn(writeAckEn), .sysTimeHostCtrl(sysTimeHostCtrl), .frameEnd(frameEnd),
      .sysTime(sysTime), .cfgLoad(cfgLoad), .cfgPulseLen(cfgPulseLen), .latchIrq(latchIrq),
      .latchIrqNet(latchIrqNet), .latchIrqHost(latchIrqHost), .syncOut(syncOut),
      .appEventReq(appEventReq), .netRdata(netRdata), .hostRdata(hostRdata));

   always #20 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic giveVerdict();
      $display("errors %0d, compares %0d", nErrors, compares);
      if (nErrors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // the run should need about 650 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         nErrors++;
         $display("unexpected at %0t: run timed out", $time);
         giveVerdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // one byte access; request held for exactly one taking edge
   task automatic acc(input bit host, input bit wr, input logic [11:0] a,
         input logic [7:0] d, output logic [7:0] q);
      dso_req_type r;
      r = '{wr: wr, rd: !wr, addr: a, wdata: d};
      @(negedge clk);
      if (host) begin
         hostReq = r;
      end else begin
         netReq = r;
      end
      @(negedge clk);
      netReq = '0;
      hostReq = '0;
      @(posedge clk);
      #1;
      q = host ? hostRdata : netRdata;
   endtask

   task automatic wrN(input bit host, input logic [11:0] a, input logic [63:0] v, input int n);
      logic [7:0] q;
      for (int i = 0; i < n; i++) begin
         acc(host, 1'b1, a + 12'(i), v[8*i +: 8], q);
      end
   endtask

   task automatic rdN(input bit host, input logic [11:0] a, input int n,
         output logic [63:0] v);
      logic [7:0] q;
      v = '0;
      for (int i = 0; i < n; i++) begin
         acc(host, 1'b0, a + 12'(i), 8'h00, q);
         v[8*i +: 8] = q;
      end
   endtask

   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask

   task automatic watch(input int idx, input int n, output int hi, output int rises);
      logic prev;
      hi = 0;
      rises = 0;
      prev = syncOut[idx];
      repeat (n) begin
         @(posedge clk);
         #1;
         if (syncOut[idx] === 1'b1) hi++;
         if (syncOut[idx] === 1'b1 && prev !== 1'b1) rises++;
         prev = syncOut[idx];
      end
   endtask

   function automatic int pulseCycles(int len);
      return (len * PULSE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction

   // upper half chosen so that the start time lies at or ahead of now
   function automatic logic [63:0] extend(logic [31:0] low, logic [63:0] now);
      logic [31:0] up;
      up = now[63:32] + 32'(low < now[31:0]);
      return {up, low};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [63:0] v, st;
      logic [31:0] low;
      logic [11:0] addrs[8];
      logic [7:0] actCfg[3];
      int hi, hi1, rs, rs1, off, plen;
      addrs = '{OWN_ADDR, ACT_ADDR, PLEN_ADDR, PLENH_ADDR, ASTAT_ADDR, S0STAT_ADDR,
         S1STAT_ADDR, 12'h9F0};
      actCfg = '{8'h22, 8'h62, 8'h22};
      void'($urandom(32'h6333ED44));
      repeat (2) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      foreach (addrs[i]) begin
         rdN(0, addrs[i], 1, v);
         `CHK(v[7:0], 8'h00)
      end
      // ownership: host cannot take it, network can
      wrN(1, OWN_ADDR, 64'hFF, 1);
      rdN(0, OWN_ADDR, 1, v);
      `CHK(v[7:0], 8'h00)
      wrN(0, OWN_ADDR, 64'hFF, 1);
      rdN(1, OWN_ADDR, 1, v);
      `CHK(v[7:0], 8'h31)
      @(negedge clk);
      latchIrq = 2'b11;
      #1;
      `CHK({latchIrqNet, latchIrqHost}, 4'b0011)
      wrN(1, ACT_ADDR, 64'h02, 1);
      wrN(0, ACT_ADDR, 64'h04, 1);
      rdN(0, ACT_ADDR, 1, v);
      `CHK(v[7:0], 8'h02)
      wrN(1, ACT_ADDR, 64'h00, 1);
      wrN(0, OWN_ADDR, 64'h20, 1);
      @(negedge clk);
      `CHK({latchIrqNet, latchIrqHost}, 4'b0110)
      sysTimeHostCtrl = 1'b1;
      #1;
      `CHK({latchIrqNet, latchIrqHost}, 4'b0011)
      sysTimeHostCtrl = 1'b0;
      // debug pulse on the first output only, random pulse length
      plen = 1 + ($urandom % 20);
      cfgPulseLen = 16'(plen);
      pulse(cfgLoad);
      rdN(1, PLEN_ADDR, 2, v);
      `CHK(v[15:0], 16'(plen))
      fork
         wrN(0, ACT_ADDR, 64'h82, 1);
         watch(0, 14, hi, rs);
         watch(1, 14, hi1, rs1);
      join
      `CHK(hi, pulseCycles(plen))
      `CHK(rs, 1)
      `CHK(hi1, 0)
      rdN(0, ACT_ADDR, 1, v);
      `CHK(v[7:0], 8'h02)
      `CHK(appEventReq, 2'b01)
      wrN(1, S0STAT_ADDR, 64'h00, 1);
      `CHK(appEventReq, 2'b01)
      rdN(1, S0STAT_ADDR, 1, v);
      `CHK(appEventReq, 2'b00)
      // cyclic run: auto activation and extension of a 32-bit start time
      // a 40 ns pulse here gives the one-cycle pulse check a cyclic start to see
      cfgPulseLen = 16'h0004;
      pulse(cfgLoad);
      wrN(0, CYC0_ADDR, 64'hFA0, 4);
      wrN(0, CYC1_ADDR, 64'h78, 4);
      wrN(0, ACT_ADDR, 64'h1E, 1);
      off = 2000 + 40 * ($urandom % 25);
      low = sysTime[31:0] + 32'(off);
      wrN(0, START_ADDR, {32'h00000000, low}, 4);
      st = extend(low, sysTime);
      pulse(frameEnd);
      repeat (3) @(posedge clk);
      rdN(0, ACT_ADDR, 1, v);
      `CHK(v[0], 1'b1)
      rdN(1, ASTAT_ADDR, 1, v);
      `CHK(v[7:0], 8'h03)
      rdN(0, START_ADDR, 8, v);
      `CHK(v, st)
      for (int i = 0; i < 200 && syncOut[0] !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      `CHK((sysTime >= st) && (sysTime < st + 64'hC8), 1'b1)
      rdN(0, START_ADDR, 8, v);
      `CHK(v, st + 64'hFA0)
      rdN(1, NEXT1_ADDR, 8, v);
      `CHK(v, st + 64'h78)
      rdN(0, ASTAT_ADDR, 1, v);
      `CHK(v[1:0], 2'b00)
      `CHK(appEventReq, 2'b11)
      rdN(1, S1STAT_ADDR, 1, v);
      `CHK(appEventReq[1], 1'b0)
      watch(0, 130, hi, rs);
      `CHK(rs, 1)
      // plausibility: past, far with short window, far with wide window
      wrN(0, CYC0_ADDR, 64'h0, 4);
      for (int i = 0; i < 3; i++) begin
         wrN(0, ACT_ADDR, 64'(actCfg[i]), 1);
         st = (i == 0) ? sysTime - 64'h3E8 : sysTime + 64'h100000000;
         wrN(0, START_ADDR, st, 8);
         pulse(frameEnd);
         fork
            wrN(0, ACT_ADDR, 64'(actCfg[i] | 8'h01), 1);
            watch(0, 20, hi, rs);
         join
         `CHK(rs, (i < 2) ? 1 : 0)
         rdN(1, ASTAT_ADDR, 1, v);
         `CHK(v[2], (i < 2) ? 1'b1 : 1'b0)
         if (i == 0) begin
            rdN(0, START_ADDR, 8, v);
            `CHK(v > st + 64'h3E8, 1'b1)
            watch(0, 150, hi, rs);
            `CHK(rs, 0)
         end
      end
      // acknowledge mode with write acknowledge
      @(negedge clk);
      writeAckEn = 1'b1;
      cfgPulseLen = 16'h0000;
      pulse(cfgLoad);
      wrN(0, ACT_ADDR, 64'h06, 1);
      wrN(0, ACT_ADDR, 64'h86, 1);
      repeat (20) @(posedge clk);
      #1;
      `CHK(syncOut, 2'b11)
      `CHK(appEventReq, 2'b11)
      rdN(1, S1STAT_ADDR, 1, v);
      `CHK(appEventReq[1], 1'b1)
      wrN(1, S0STAT_ADDR, 64'h00, 1);
      `CHK(appEventReq, 2'b10)
      wrN(1, S1STAT_ADDR, 64'h00, 1);
      `CHK(appEventReq, 2'b00)
      `CHK(syncOut, 2'b00)
      giveVerdict();
   end
endmodule
